// ==== design/cct_cfg.svh ====
`ifndef CCT_CFG_SVH
`define CCT_CFG_SVH

// ============================================================
// register addresses
`define CCT_ADDR_W 20
`define CCT_ADDR_CTRL2 20'hfff90
`define CCT_ADDR_CTRL3 20'hfff91
`define CCT_ADDR_CNT2 20'hfff94
`define CCT_ADDR_CNT3 20'hfff95
`define CCT_ADDR_CMPA2 20'hfff96
`define CCT_ADDR_CMPA3 20'hfff97
`define CCT_ADDR_CMPB2 20'hfff98
`define CCT_ADDR_CMPB3 20'hfff99
`define CCT_ADDR_STATUS 20'hfff9a
`define CCT_ADDR_MASK 20'hfff9b
`define CCT_ADDR_CAPCFG 20'hfff9c

// ============================================================
// control register fields
`define CCT_F_MB_IE 7
`define CCT_F_MA_IE 6
`define CCT_F_OVF_IE 5
`define CCT_F_CLR_HI 4
`define CCT_F_CLR_LO 3
`define CCT_F_CKS_HI 2
`define CCT_F_CKS_LO 0

// ============================================================
// clock select codes
`define CCT_CKS_OFF 3'h0
`define CCT_CKS_CASC 3'h4
`define CCT_CKS_FALL 3'h5
`define CCT_CKS_RISE 3'h6
`define CCT_CKS_BOTH 3'h7

// ============================================================
// clear select codes
`define CCT_CLR_NONE 2'h0
`define CCT_CLR_MA 2'h1
`define CCT_CLR_MB_CAP 2'h2
`define CCT_CLR_CAP 2'h3

// ============================================================
// status layout, three bits per channel
`define CCT_ST_W 6
`define CCT_ST_OVF 0
`define CCT_ST_MA 1
`define CCT_ST_MB 2

// ============================================================
// reset values and prescale defaults
`define CCT_CTRL_RST 8'h00
`define CCT_CMP_RST 8'hff
`define CCT_DIV_SEL1 8
`define CCT_DIV_SEL2 64
`define CCT_DIV_SEL3 8192
`define CCT_PRESC_W 13

`endif

// ==== design/cct_pkg.sv ====
package cct_pkg;
    typedef logic [7:0] cct_byte_t;
    typedef logic [19:0] cct_addr_t;
    typedef logic [1:0] cct_clr_t;
endpackage

// ==== design/cct_chan.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cct_cfg.svh"

module cct_chan (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire cct_pkg::cct_clr_t clear_sel,
    input wire cct_pkg::cct_byte_t cmpa,
    input wire cct_pkg::cct_byte_t cmpb,
    input wire logic cap_mode,
    input wire logic cap_edge,
    input wire logic cnt_we,
    input wire cct_pkg::cct_byte_t cnt_wdata,
    output cct_pkg::cct_byte_t cnt,
    output logic ovf_evt,
    output logic ma_evt,
    output logic mb_evt,
    output logic cap_evt
);
    import cct_pkg::*;

    cct_byte_t cnt_reg;
    cct_byte_t cnt_next;
    logic upd_reg;
    logic ovf_reg;
    logic clear_hit;
    logic step;

    // ============================================================
    // events
    assign ma_evt = upd_reg && (cnt_reg == cmpa);
    assign mb_evt = upd_reg && !cap_mode && (cnt_reg == cmpb);
    assign cap_evt = cap_mode && cap_edge;
    assign clear_hit = (clear_sel == `CCT_CLR_MA && ma_evt) ||
        (clear_sel == `CCT_CLR_MB_CAP && (mb_evt || cap_evt)) ||
        (clear_sel == `CCT_CLR_CAP && cap_evt);
    assign step = tick && !clear_hit && !cnt_we;
    assign cnt_next = cnt_we ? cnt_wdata :
        clear_hit ? 8'h00 :
        step ? cnt_reg + 8'h01 : cnt_reg;
    assign cnt = cnt_reg;
    assign ovf_evt = ovf_reg;

    // ============================================================
    // counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 8'h00;
            upd_reg <= 1'b0;
            ovf_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            upd_reg <= cnt_next != cnt_reg;
            ovf_reg <= step && (cnt_reg == 8'hff);
        end
    end

    // ============================================================
    // checks
    AST_STEP_ONE: assert property (@(posedge clk) disable iff (!rst_n)
        step |=> cnt_reg == $past(cnt_reg) + 8'h01)
        else $error("counter did not step by one");
    AST_CLEAR_MA: assert property (@(posedge clk) disable iff (!rst_n)
        (clear_sel == `CCT_CLR_MA && ma_evt && !cnt_we) |=> cnt_reg == 8'h00)
        else $error("match a did not clear counter");
    AST_CLEAR_CAP: assert property (@(posedge clk) disable iff (!rst_n)
        (clear_sel == `CCT_CLR_CAP && cap_evt && !cnt_we) |=>
        cnt_reg == 8'h00)
        else $error("capture b did not clear counter");
    AST_NO_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        (clear_sel == `CCT_CLR_NONE && !tick && !cnt_we) |=> $stable(cnt_reg))
        else $error("counter moved with clearing disabled");
    AST_OVF_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
        (step && cnt_reg == 8'hff) |=> (ovf_reg && cnt_reg == 8'h00))
        else $error("overflow not flagged at wrap");
endmodule

`default_nettype wire

// ==== design/cct_timer.sv ====
// Functional notes
// - clock select zero gives no count clock; counter holds.
// - internal selections count on prescaled ticks, including /64 and /8192.
// - channel 2 cascade counts once per channel 3 overflow.
// - channel 3 cascade counts once per channel 2 match A.
// - both channels on cascade give no count clock; software avoids it.
// - external selections count on falling, rising or both pin edges.
// - clear code 00 never clears; 01 clears on match A.
// - clear code 10 clears on match B or capture; 11 on capture.
// - overflow enable gates overflow flag onto overflow request.
// - match A enable gates match A flag onto its request.
// - match B enable gates match B/capture flag onto its request.
`timescale 1ns/1ps
`default_nettype none
`include "cct_cfg.svh"

module cct_timer #(
    parameter int DIV_SEL1 = `CCT_DIV_SEL1,
    parameter int DIV_SEL2 = `CCT_DIV_SEL2,
    parameter int DIV_SEL3 = `CCT_DIV_SEL3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire cct_pkg::cct_addr_t addr,
    input wire cct_pkg::cct_byte_t wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output cct_pkg::cct_byte_t rdata,
    input wire logic ext_clk_pin,
    input wire logic [1:0] capture_b_pin,
    output logic [1:0] overflow_irq,
    output logic [1:0] match_a_irq,
    output logic [1:0] match_b_irq,
    output logic irq
);
    import cct_pkg::*;

    localparam int NCH = 2;
    localparam logic [`CCT_PRESC_W-1:0] MASK1 = `CCT_PRESC_W'(DIV_SEL1 - 1);
    localparam logic [`CCT_PRESC_W-1:0] MASK2 = `CCT_PRESC_W'(DIV_SEL2 - 1);
    localparam logic [`CCT_PRESC_W-1:0] MASK3 = `CCT_PRESC_W'(DIV_SEL3 - 1);

    // ============================================================
    // prescaler
    logic [`CCT_PRESC_W-1:0] presc_reg;
    logic tick1;
    logic tick2;
    logic tick3;

    assign tick1 = (presc_reg & MASK1) == MASK1;
    assign tick2 = (presc_reg & MASK2) == MASK2;
    assign tick3 = (presc_reg & MASK3) == MASK3;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_reg <= '0;
        end else begin
            presc_reg <= presc_reg + `CCT_PRESC_W'(1);
        end
    end

    // ============================================================
    // external clock pin synchroniser
    logic ext_meta_reg;
    logic ext_sync_reg;
    logic ext_prev_reg;
    logic ext_rise;
    logic ext_fall;

    assign ext_rise = ext_sync_reg && !ext_prev_reg;
    assign ext_fall = !ext_sync_reg && ext_prev_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            ext_meta_reg <= ext_clk_pin;
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
        end
    end

    // ============================================================
    // shared registers
    logic [`CCT_ST_W-1:0] status_reg;
    logic [`CCT_ST_W-1:0] status_next;
    logic [`CCT_ST_W-1:0] status_set;
    logic [`CCT_ST_W-1:0] mask_reg;
    logic [NCH-1:0] capcfg_reg;
    logic hit_status;
    logic hit_mask;
    logic hit_capcfg;

    assign hit_status = addr == `CCT_ADDR_STATUS;
    assign hit_mask = addr == `CCT_ADDR_MASK;
    assign hit_capcfg = addr == `CCT_ADDR_CAPCFG;
    // set wins over a write-one clear
    assign status_next = status_set | (status_reg &
        ~((wr_en && hit_status) ? wdata[`CCT_ST_W-1:0] : `CCT_ST_W'(0)));
    assign irq = |(status_reg & mask_reg);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= '0;
            mask_reg <= '0;
            capcfg_reg <= '0;
        end else begin
            status_reg <= status_next;
            if (wr_en && hit_mask) begin
                mask_reg <= wdata[`CCT_ST_W-1:0];
            end
            if (wr_en && hit_capcfg) begin
                capcfg_reg <= wdata[NCH-1:0];
            end
        end
    end

    // ============================================================
    // per-channel signals
    cct_byte_t ctrl_reg [NCH];
    cct_byte_t cmpa_reg [NCH];
    cct_byte_t cmpb_reg [NCH];
    cct_byte_t cnt [NCH];
    logic [2:0] cks [NCH];
    logic [NCH-1:0] tick;
    logic [NCH-1:0] ovf_evt;
    logic [NCH-1:0] ma_evt;
    logic [NCH-1:0] mb_evt;
    logic [NCH-1:0] cap_evt;
    logic [NCH-1:0] casc_src;
    logic [NCH-1:0] cnt_we;
    logic [NCH-1:0] hit_ctrl;
    logic [NCH-1:0] hit_cnt;
    logic [NCH-1:0] hit_cmpa;
    logic [NCH-1:0] hit_cmpb;
    logic casc_lock;

    assign casc_src[0] = ovf_evt[1];
    assign casc_src[1] = ma_evt[0];
    assign casc_lock = (cks[0] == `CCT_CKS_CASC) &&
        (cks[1] == `CCT_CKS_CASC);

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gen_ch
            logic cap_meta_reg;
            logic cap_sync_reg;
            logic cap_prev_reg;
            logic cap_edge;
            logic [7:0] src;

            assign hit_ctrl[g] = addr == `CCT_ADDR_W'(`CCT_ADDR_CTRL2 + g);
            assign hit_cnt[g] = addr == `CCT_ADDR_W'(`CCT_ADDR_CNT2 + g);
            assign hit_cmpa[g] = addr == `CCT_ADDR_W'(`CCT_ADDR_CMPA2 + g);
            assign hit_cmpb[g] = addr == `CCT_ADDR_W'(`CCT_ADDR_CMPB2 + g);
            assign cnt_we[g] = wr_en && hit_cnt[g];
            assign cks[g] = ctrl_reg[g][`CCT_F_CKS_HI:`CCT_F_CKS_LO];
            assign cap_edge = cap_sync_reg && !cap_prev_reg;
            assign src = {ext_rise || ext_fall, ext_rise, ext_fall,
                casc_src[g] && !casc_lock,
                tick3, tick2, tick1,
                1'b0};
            assign tick[g] = src[cks[g]];
            assign status_set[3 * g + `CCT_ST_OVF] = ovf_evt[g];
            assign status_set[3 * g + `CCT_ST_MA] = ma_evt[g];
            assign status_set[3 * g + `CCT_ST_MB] = mb_evt[g] || cap_evt[g];
            assign overflow_irq[g] = status_reg[3 * g + `CCT_ST_OVF] &&
                ctrl_reg[g][`CCT_F_OVF_IE];
            assign match_a_irq[g] = status_reg[3 * g + `CCT_ST_MA] &&
                ctrl_reg[g][`CCT_F_MA_IE];
            assign match_b_irq[g] = status_reg[3 * g + `CCT_ST_MB] &&
                ctrl_reg[g][`CCT_F_MB_IE];

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    cap_meta_reg <= 1'b0;
                    cap_sync_reg <= 1'b0;
                    cap_prev_reg <= 1'b0;
                end else begin
                    cap_meta_reg <= capture_b_pin[g];
                    cap_sync_reg <= cap_meta_reg;
                    cap_prev_reg <= cap_sync_reg;
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    ctrl_reg[g] <= `CCT_CTRL_RST;
                    cmpa_reg[g] <= `CCT_CMP_RST;
                    cmpb_reg[g] <= `CCT_CMP_RST;
                end else begin
                    if (wr_en && hit_ctrl[g]) begin
                        ctrl_reg[g] <= wdata;
                    end
                    if (wr_en && hit_cmpa[g]) begin
                        cmpa_reg[g] <= wdata;
                    end
                    if (wr_en && hit_cmpb[g]) begin
                        cmpb_reg[g] <= wdata;
                    end else if (cap_evt[g]) begin
                        cmpb_reg[g] <= cnt[g];
                    end
                end
            end

            cct_chan u_chan (
                .clk(clk),
                .rst_n(rst_n),
                .tick(tick[g]),
                .clear_sel(ctrl_reg[g][`CCT_F_CLR_HI:`CCT_F_CLR_LO]),
                .cmpa(cmpa_reg[g]),
                .cmpb(cmpb_reg[g]),
                .cap_mode(capcfg_reg[g]),
                .cap_edge(cap_edge),
                .cnt_we(cnt_we[g]),
                .cnt_wdata(wdata),
                .cnt(cnt[g]),
                .ovf_evt(ovf_evt[g]),
                .ma_evt(ma_evt[g]),
                .mb_evt(mb_evt[g]),
                .cap_evt(cap_evt[g])
            );

            AST_NO_CLOCK: assert property (@(posedge clk)
                disable iff (!rst_n)
                (cks[g] == `CCT_CKS_OFF) |-> !tick[g])
                else $error("count clock present while disabled");
            AST_EXT_RISE: assert property (@(posedge clk)
                disable iff (!rst_n)
                (cks[g] == `CCT_CKS_RISE) |-> tick[g] == ext_rise)
                else $error("rising edge select mismatch");
            AST_EXT_FALL: assert property (@(posedge clk)
                disable iff (!rst_n)
                (cks[g] == `CCT_CKS_FALL) |-> tick[g] == ext_fall)
                else $error("falling edge select mismatch");
            AST_EXT_BOTH: assert property (@(posedge clk)
                disable iff (!rst_n)
                (cks[g] == `CCT_CKS_BOTH && $changed(ext_sync_reg)) |->
                tick[g])
                else $error("both edge select missed an edge");
            AST_OVF_IRQ: assert property (@(posedge clk)
                disable iff (!rst_n)
                (ovf_evt[g] && ctrl_reg[g][`CCT_F_OVF_IE] && !wr_en) |=>
                overflow_irq[g])
                else $error("overflow request not raised");
            AST_MA_IRQ: assert property (@(posedge clk)
                disable iff (!rst_n)
                !ctrl_reg[g][`CCT_F_MA_IE] |-> !match_a_irq[g])
                else $error("match a request while disabled");
            AST_MA_IRQ_SET: assert property (@(posedge clk)
                disable iff (!rst_n)
                (ma_evt[g] && ctrl_reg[g][`CCT_F_MA_IE] && !wr_en) |=>
                match_a_irq[g])
                else $error("match a request not raised");
            AST_MB_IRQ: assert property (@(posedge clk)
                disable iff (!rst_n)
                ((mb_evt[g] || cap_evt[g]) && ctrl_reg[g][`CCT_F_MB_IE] &&
                !wr_en) |=> match_b_irq[g])
                else $error("match b request not raised");
        end
    endgenerate

    AST_CASC_CH2: assert property (@(posedge clk)
        disable iff (!rst_n)
        (cks[0] == `CCT_CKS_CASC && !casc_lock) |->
        tick[0] == ovf_evt[1])
        else $error("channel 2 cascade tick mismatch");
    AST_CASC_CH3: assert property (@(posedge clk)
        disable iff (!rst_n)
        (cks[1] == `CCT_CKS_CASC && !casc_lock) |->
        tick[1] == ma_evt[0])
        else $error("channel 3 cascade tick mismatch");
    AST_CASC_LOCK: assert property (@(posedge clk)
        disable iff (!rst_n)
        casc_lock |-> (tick == 2'b00))
        else $error("count clock present in cascade lock");
    AST_PRESC64: assert property (@(posedge clk)
        disable iff (!rst_n)
        tick2 |-> ##64 tick2)
        else $error("prescale 64 period wrong");
    AST_SET_WINS: assert property (@(posedge clk)
        disable iff (!rst_n)
        (status_set != '0) |=> (status_reg & $past(status_set)) ==
        $past(status_set))
        else $error("status event lost to a clear");

    // ============================================================
    // prescale period checks
    logic [`CCT_PRESC_W-1:0] gap1_reg;
    logic [`CCT_PRESC_W-1:0] gap3_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap1_reg <= '0;
            gap3_reg <= '0;
        end else begin
            gap1_reg <= tick1 ? '0 : gap1_reg + `CCT_PRESC_W'(1);
            gap3_reg <= tick3 ? '0 : gap3_reg + `CCT_PRESC_W'(1);
        end
    end

    AST_PRESC_SEL1: assert property (@(posedge clk)
        disable iff (!rst_n)
        tick1 == (gap1_reg == MASK1))
        else $error("first prescale period wrong");
    AST_PRESC8192: assert property (@(posedge clk)
        disable iff (!rst_n)
        tick3 == (gap3_reg == MASK3))
        else $error("prescale 8192 period wrong");

    // ============================================================
    // read port
    cct_byte_t rd_mux;
    cct_byte_t rdata_reg;

    assign rd_mux = hit_ctrl[0] ? ctrl_reg[0] :
        hit_ctrl[1] ? ctrl_reg[1] :
        hit_cnt[0] ? cnt[0] :
        hit_cnt[1] ? cnt[1] :
        hit_cmpa[0] ? cmpa_reg[0] :
        hit_cmpa[1] ? cmpa_reg[1] :
        hit_cmpb[0] ? cmpb_reg[0] :
        hit_cmpb[1] ? cmpb_reg[1] :
        hit_status ? {2'b00, status_reg} :
        hit_mask ? {2'b00, mask_reg} :
        hit_capcfg ? {6'h00, capcfg_reg} : 8'h00;
    assign rdata = rdata_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rd_en ? rd_mux : 8'h00;
        end
    end
endmodule

`default_nettype wire

// ==== tb/cct_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// far side: external count clock pin and capture pins
module cct_pin_model (
    input wire logic clk,
    output var logic ext_clk_pin,
    output var logic [1:0] capture_b_pin
);
    initial begin
        ext_clk_pin = 1'b0;
        capture_b_pin = 2'b00;
    end

    // full pulses, pin idles low, then settle time
    task automatic pulses(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (4) @(posedge clk);
            ext_clk_pin <= 1'b1;
            repeat (4) @(posedge clk);
            ext_clk_pin <= 1'b0;
        end
        repeat (6) @(posedge clk);
    endtask

    // one rising edge on a capture pin
    task automatic capture(input int ch);
        @(posedge clk);
        capture_b_pin[ch] <= 1'b1;
        repeat (4) @(posedge clk);
        capture_b_pin[ch] <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
endmodule

`default_nettype wire

// ==== tb/tb_cascadable_8bit_timer_control.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cct_cfg.svh"

`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
    errors++; $display("[ERR] %s expected %h seen %h", nm, ex, got); end end

module tb_cascadable_8bit_timer_control;
    import cct_pkg::*;
    logic clk;
    logic rst_n;
    cct_addr_t addr;
    cct_byte_t wdata;
    cct_byte_t rdata;
    logic wr_en;
    logic rd_en;
    wire ext_clk_pin;
    wire [1:0] capture_b_pin;
    logic [1:0] overflow_irq;
    logic [1:0] match_a_irq;
    logic [1:0] match_b_irq;
    logic irq;
    int errors = 0;
    int check_count = 0;
    cct_byte_t exp_q[$];
    string nm_q[$];
    cct_byte_t m_exp;
    string m_nm;
    cct_byte_t v;
    logic rd_d = 1'b0;
    int dv[3] = '{`CCT_DIV_SEL1, `CCT_DIV_SEL2, `CCT_DIV_SEL3};
    int ks[3] = '{4, 3, 2};

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    cct_timer dut (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .ext_clk_pin(ext_clk_pin), .capture_b_pin(capture_b_pin),
        .overflow_irq(overflow_irq), .match_a_irq(match_a_irq),
        .match_b_irq(match_b_irq), .irq(irq)
    );

    cct_pin_model pm (
        .clk(clk), .ext_clk_pin(ext_clk_pin), .capture_b_pin(capture_b_pin)
    );

    // ============================================================
    // register bus
    task automatic wr(input cct_addr_t a, input cct_byte_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(input cct_addr_t a, input cct_byte_t e, input string n);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        exp_q.push_back(e);
        nm_q.push_back(n);
        @(posedge clk);
        rd_en <= 1'b0;
    endtask

    // read data monitor, oldest note first
    always @(posedge clk) begin
        rd_d <= rd_en;
        if (rd_d === 1'b1) begin
            if (exp_q.size() == 0) begin
                errors++;
                $display("[ERR] rdata expected none seen %h", rdata);
            end else begin
                m_exp = exp_q.pop_front();
                m_nm = nm_q.pop_front();
                `CHK(m_nm, m_exp, rdata)
            end
        end
    end

    // ============================================================
    // reporting
    task automatic done_test(input string n);
        $display("test %s done", n);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        $display("[ERR] run expected done seen hang");
        give_verdict();
    end

    // ============================================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        addr = '0;
        wdata = '0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        void'($urandom(77883));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(`CCT_ADDR_CTRL2, 8'h00, "ctrl2 reset");
        rd(`CCT_ADDR_CTRL3, 8'h00, "ctrl3 reset");
        rd(`CCT_ADDR_CNT2, 8'h00, "cnt2 reset");
        rd(`CCT_ADDR_CMPA2, 8'hff, "cmpa2 reset");
        rd(`CCT_ADDR_STATUS, 8'h00, "status reset");
        wr(20'hfff9f, 8'h5a);
        rd(20'hfff9f, 8'h00, "unmapped");
        `CHK("irq reset", 1'b0, irq)
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            wr(`CCT_ADDR_CTRL2, v);
            wr(`CCT_ADDR_CTRL3, ~v);
            rd(`CCT_ADDR_CTRL2, v, "ctrl2 rw");
            rd(`CCT_ADDR_CTRL3, ~v, "ctrl3 rw");
        end
        done_test("registers");
        wr(`CCT_ADDR_CTRL2, 8'h00);
        wr(`CCT_ADDR_CTRL3, 8'h00);
        wr(`CCT_ADDR_CNT2, 8'h00);
        wr(`CCT_ADDR_CNT3, 8'h00);
        wr(`CCT_ADDR_STATUS, 8'h3f);
        pm.pulses(3);
        rd(`CCT_ADDR_CNT2, 8'h00, "cnt2 off");
        wr(`CCT_ADDR_CMPA2, 8'h01);
        for (int c = 5; c < 8; c++) begin
            wr(`CCT_ADDR_CNT2, 8'h00);
            wr(`CCT_ADDR_CTRL2, 8'(c));
            pm.pulses(3);
            wr(`CCT_ADDR_CTRL2, 8'h00);
            rd(`CCT_ADDR_CNT2, (c == 7) ? 8'h06 : 8'h03, "cnt2 ext");
        end
        done_test("external");
        for (int i = 0; i < 3; i++) begin
            wr(`CCT_ADDR_CNT2, 8'h00);
            wr(`CCT_ADDR_CTRL2, 8'(i + 1));
            repeat (ks[i] * dv[i] - 2) @(posedge clk);
            wr(`CCT_ADDR_CTRL2, 8'h00);
            rd(`CCT_ADDR_CNT2, 8'(ks[i]), "cnt2 presc");
        end
        done_test("prescale");
        wr(`CCT_ADDR_CNT2, 8'h00);
        wr(`CCT_ADDR_CNT3, 8'hfe);
        wr(`CCT_ADDR_CTRL3, 8'h06);
        wr(`CCT_ADDR_CTRL2, 8'h04);
        pm.pulses(3);
        wr(`CCT_ADDR_CTRL3, 8'h00);
        rd(`CCT_ADDR_CNT3, 8'h01, "cnt3 ext");
        rd(`CCT_ADDR_CNT2, 8'h01, "cnt2 casc");
        wr(`CCT_ADDR_CTRL2, 8'h00);
        wr(`CCT_ADDR_CNT2, 8'h00);
        wr(`CCT_ADDR_CNT3, 8'h00);
        wr(`CCT_ADDR_CMPA2, 8'h02);
        wr(`CCT_ADDR_CTRL3, 8'h04);
        wr(`CCT_ADDR_CTRL2, 8'h0e);
        pm.pulses(6);
        rd(`CCT_ADDR_CNT3, 8'h03, "cnt3 casc");
        rd(`CCT_ADDR_CNT2, 8'h00, "cnt2 clr ma");
        wr(`CCT_ADDR_CTRL2, 8'h04);
        wr(`CCT_ADDR_CNT2, 8'h02);
        pm.pulses(2);
        wr(`CCT_ADDR_CTRL2, 8'h00);
        wr(`CCT_ADDR_CTRL3, 8'h00);
        rd(`CCT_ADDR_CNT3, 8'h03, "cnt3 both casc");
        rd(`CCT_ADDR_CNT2, 8'h02, "cnt2 both casc");
        done_test("cascade");
        wr(`CCT_ADDR_CNT2, 8'h00);
        wr(`CCT_ADDR_CMPB2, 8'h03);
        wr(`CCT_ADDR_CTRL2, 8'h16);
        pm.pulses(3);
        rd(`CCT_ADDR_CNT2, 8'h00, "cnt2 clr mb");
        wr(`CCT_ADDR_CTRL2, 8'h1e);
        pm.pulses(3);
        rd(`CCT_ADDR_CNT2, 8'h03, "cnt2 no clr mb");
        wr(`CCT_ADDR_CAPCFG, 8'h03);
        wr(`CCT_ADDR_CMPB2, 8'h5a);
        wr(`CCT_ADDR_CTRL3, 8'h10);
        pm.capture(0);
        pm.capture(1);
        rd(`CCT_ADDR_CNT2, 8'h00, "cnt2 clr cap");
        rd(`CCT_ADDR_CMPB2, 8'h03, "cmpb2 cap");
        rd(`CCT_ADDR_CNT3, 8'h00, "cnt3 clr cap");
        rd(`CCT_ADDR_CMPB3, 8'h03, "cmpb3 cap");
        wr(`CCT_ADDR_CTRL2, 8'h00);
        wr(`CCT_ADDR_CAPCFG, 8'h00);
        done_test("clear");
        wr(`CCT_ADDR_STATUS, 8'h3f);
        wr(`CCT_ADDR_CMPA2, 8'h01);
        wr(`CCT_ADDR_CMPB2, 8'h02);
        wr(`CCT_ADDR_CNT2, 8'hff);
        wr(`CCT_ADDR_CTRL2, 8'he6);
        pm.pulses(1);
        `CHK("ovf irq", 2'b01, overflow_irq)
        `CHK("ma irq", 2'b00, match_a_irq)
        pm.pulses(1);
        `CHK("ma irq", 2'b01, match_a_irq)
        `CHK("mb irq", 2'b00, match_b_irq)
        pm.pulses(1);
        `CHK("mb irq", 2'b01, match_b_irq)
        `CHK("irq masked", 1'b0, irq)
        wr(`CCT_ADDR_MASK, 8'h07);
        `CHK("irq unmasked", 1'b1, irq)
        wr(`CCT_ADDR_CTRL2, 8'h06);
        `CHK("ovf irq off", 2'b00, overflow_irq)
        `CHK("ma irq off", 2'b00, match_a_irq)
        `CHK("mb irq off", 2'b00, match_b_irq)
        rd(`CCT_ADDR_STATUS, 8'h07, "status set");
        wr(`CCT_ADDR_STATUS, 8'h07);
        `CHK("irq cleared", 1'b0, irq)
        rd(`CCT_ADDR_STATUS, 8'h00, "status clr");
        done_test("interrupts");
        repeat (4) @(posedge clk);
        `CHK("pending reads", 0, exp_q.size())
        give_verdict();
    end
endmodule

`default_nettype wire
